// ---- gpte_eval.sv ----
// Run-mode evaluator for a multi-input gauge column: peaks, runout,
// limit window, check selection and record offload.
// Assumes operator inputs are one-cycle pulses synchronous to clock_i.
//
// Functional notes
// - Max hold shows largest reading since last reset command.
// - Min hold shows smallest reading since last reset command.
// - Runout shows running maximum minus running minimum since reset.
// - Configurable automatic reset clears peaks without operator press.
// - Six functions: bypass, average, max, min, limit window, runout.
// - Bypass shows the live reading continuously.
// - Each selector step without a press in the run menu changes the shown check when two or more.
// - Limit window shows average when inside limits.
// - Limit window shows both peaks when outside limits.
// - First press shows offload prompt, second press starts sending.
// - Single and multi-check programs send every defined check.
// - Multi-fixture programs send only the shown reading.
// - Foot pedal acts as the selector press for offload.
// - Record holds name, result, scale, status and class.
// - Single-check program allows only bypass, max, min, runout.
`timescale 1ns/1ns
`default_nettype none
module gpte_eval
	import gpte_pkg::*;
(
	// Clock and reset
	input wire logic clock_i,
	input wire logic rst_n_i,
	// AHB-Lite slave
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	// Gauge readings and operator
	input wire logic [NCHK*W-1:0] reading_i,
	input wire logic hold_reset_i,
	input wire logic rotate_step_i,
	input wire logic select_press_i,
	input wire logic foot_pedal_i,
	// Display
	output logic [W-1:0] disp_value_o,
	output logic [W-1:0] disp_aux_o,
	output logic disp_dual_o,
	output logic [CW-1:0] disp_check_o,
	output logic [1:0] disp_status_o,
	output logic offload_prompt_o,
	// Offload records
	output logic rec_valid_o,
	input wire logic rec_ready_i,
	output logic [CW-1:0] rec_check_o,
	output logic [W-1:0] rec_result_o,
	output logic [1:0] rec_scale_o,
	output logic [1:0] rec_status_o,
	output logic [1:0] rec_class_o,
	output logic rec_class_vld_o,
	output logic rec_last_o
);
	// ----------------------------------------
	// Evaluation functions
	// ----------------------------------------
	function automatic logic signed [W-1:0] avg_of(input logic signed [W-1:0] mx,
		input logic signed [W-1:0] mn);
		logic signed [W:0] s;
		s = {mx[W-1], mx} + {mn[W-1], mn};
		return s[W:1];
	endfunction : avg_of

	function automatic logic outside(input logic signed [W-1:0] mx,
		input logic signed [W-1:0] mn, input logic signed [W-1:0] hi,
		input logic signed [W-1:0] lo);
		return (mx > hi) || (mn < lo);
	endfunction : outside

	// Result value of one check under a function
	function automatic logic signed [W-1:0] eval_of(input gpte_func_t fn,
		input logic signed [W-1:0] lv, input logic signed [W-1:0] mx,
		input logic signed [W-1:0] mn, input logic out);
		logic signed [W-1:0] r;
		r = lv;
		unique case (fn)
			GPTE_FN_BYPASS: r = lv;
			GPTE_FN_AVG: r = avg_of(mx, mn);
			GPTE_FN_MAX: r = mx;
			GPTE_FN_MIN: r = mn;
			GPTE_FN_LIMIT: r = out ? mx : avg_of(mx, mn);
			GPTE_FN_RUNOUT: r = W'(mx - mn);
			default: r = lv;
		endcase
		return r;
	endfunction : eval_of

	function automatic gpte_stat_t stat_of(input logic signed [W-1:0] v,
		input logic signed [W-1:0] mn, input logic peaks,
		input logic signed [W-1:0] hi, input logic signed [W-1:0] lo);
		gpte_stat_t st;
		st = GPTE_ST_IN;
		if (v > hi) begin
			st = GPTE_ST_OVER;
		end else if ((peaks ? mn : v) < lo) begin
			st = GPTE_ST_UNDER;
		end
		return st;
	endfunction : stat_of

	// ----------------------------------------
	// Registers and bus slave
	// ----------------------------------------
	logic [31:0] ctrl_q;
	logic [31:0] arst_q;
	logic [31:0] limit_q;
	logic [1:0] scale_q;
	logic [31:0] hrdata_q;
	logic wr_pend_q;
	logic [7:0] wr_addr_q;
	logic sw_clr_q;
	logic [31:0] arst_cnt_q;
	logic [CW-1:0] sel_q;
	gpte_menu_t menu_q;

	wire acc = hsel_i && hready_i && (htrans_i == GPTE_HTRANS_NONSEQ);
	wire acc_wr = acc && hwrite_i && (hsize_i == GPTE_HSIZE_WORD);
	wire acc_rd = acc && !hwrite_i;
	wire [7:0] ra = haddr_i[7:0];
	wire hit_ctrl = wr_pend_q && (wr_addr_q == GPTE_OFF_CTRL);
	wire hit_arst = wr_pend_q && (wr_addr_q == GPTE_OFF_ARST);
	wire hit_limit = wr_pend_q && (wr_addr_q == GPTE_OFF_LIMIT);
	wire hit_scale = wr_pend_q && (wr_addr_q == GPTE_OFF_SCALE);
	wire hit_cmd = wr_pend_q && (wr_addr_q == GPTE_OFF_CMD);

	// Illegal function for a single-check program falls back to bypass
	wire [2:0] wr_fn = hwdata_i[GPTE_CTRL_FN_LSB +: 3];
	wire [1:0] wr_pg = hwdata_i[GPTE_CTRL_PG_LSB +: 2];
	wire fn_bad = (wr_fn > GPTE_FN_RUNOUT) || ((wr_pg == GPTE_PG_SINGLE) &&
		((wr_fn == GPTE_FN_AVG) || (wr_fn == GPTE_FN_LIMIT)));
	wire [2:0] fn_new = fn_bad ? GPTE_FN_BYPASS : wr_fn;
	wire [31:0] ctrl_d = {hwdata_i[31:3], fn_new};

	gpte_func_t fn;
	gpte_prog_t pg;
	assign fn = gpte_func_t'(ctrl_q[GPTE_CTRL_FN_LSB +: 3]);
	assign pg = gpte_prog_t'(ctrl_q[GPTE_CTRL_PG_LSB +: 2]);
	wire auto_en = ctrl_q[GPTE_CTRL_AUTO_BIT];
	wire [CW-1:0] ncm1 = ctrl_q[GPTE_CTRL_NCHK_LSB +: CW];
	wire signed [W-1:0] hi = limit_q[GPTE_LIMIT_HI_LSB +: W];
	wire signed [W-1:0] lo = limit_q[W-1:0];

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= 8'h00;
		end else begin
			wr_pend_q <= acc_wr;
			wr_addr_q <= ra;
		end
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ctrl_q <= GPTE_CTRL_RST;
			arst_q <= GPTE_ARST_RST;
			limit_q <= GPTE_LIMIT_RST;
			scale_q <= GPTE_SCALE_RST;
			sw_clr_q <= 1'b0;
		end else begin
			if (hit_ctrl) ctrl_q <= ctrl_d;
			if (hit_arst) arst_q <= hwdata_i;
			if (hit_limit) limit_q <= hwdata_i;
			if (hit_scale) scale_q <= hwdata_i[1:0];
			sw_clr_q <= hit_cmd && hwdata_i[GPTE_CMD_CLR_BIT];
		end
	end

	// ----------------------------------------
	// Peak trackers and hold clearing
	// ----------------------------------------
	// Auto reset period counts clocks; it restarts on every clear
	wire arst_hit = auto_en && (arst_cnt_q >= arst_q - 32'h1);
	wire hold_clr = hold_reset_i || sw_clr_q || arst_hit;

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			arst_cnt_q <= 32'h0;
		end else begin
			arst_cnt_q <= (hold_clr || !auto_en) ? 32'h0 : arst_cnt_q + 32'h1;
		end
	end

	logic signed [W-1:0] live_w [NCHK];
	logic signed [W-1:0] max_w [NCHK];
	logic signed [W-1:0] min_w [NCHK];

	for (genvar g = 0; g < NCHK; g++) begin : g_trk
		assign live_w[g] = reading_i[g*W +: W];
		gpte_peak_track u_trk (
			.clock_i(clock_i),
			.rst_n_i(rst_n_i),
			.live_i(live_w[g]),
			.clear_i(hold_clr),
			.max_o(max_w[g]),
			.min_o(min_w[g])
		);
	end

	// ----------------------------------------
	// Display path
	// ----------------------------------------
	wire signed [W-1:0] s_live = live_w[sel_q];
	wire signed [W-1:0] s_max = max_w[sel_q];
	wire signed [W-1:0] s_min = min_w[sel_q];
	wire s_out = outside(s_max, s_min, hi, lo);
	wire s_dual = (fn == GPTE_FN_LIMIT) && s_out;
	wire signed [W-1:0] s_val = eval_of(fn, s_live, s_max, s_min, s_out);
	gpte_stat_t s_st;
	assign s_st = stat_of(s_val, s_min, s_dual, hi, lo);

	logic [W-1:0] disp_value_q;
	logic [W-1:0] disp_aux_q;
	logic disp_dual_q;
	logic [1:0] disp_st_q;

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			disp_value_q <= '0;
			disp_aux_q <= '0;
			disp_dual_q <= 1'b0;
			disp_st_q <= GPTE_ST_IN;
		end else begin
			disp_value_q <= s_val;
			disp_aux_q <= s_dual ? s_min : s_val;
			disp_dual_q <= s_dual;
			disp_st_q <= s_st;
		end
	end

	// ----------------------------------------
	// Selector and offload menu
	// ----------------------------------------
	// Pedal stands in for the selector press in the offload menu
	wire press = select_press_i || foot_pedal_i;
	logic [CW-1:0] idx_q;
	logic rec_valid_q;
	wire fixture = (pg == GPTE_PG_FIXTURE);
	wire idx_last = fixture || (idx_q == ncm1);
	wire rec_take = rec_valid_q && rec_ready_i;
	wire go_send = (menu_q == GPTE_MN_PROMPT) && press;
	wire next_rec = rec_take && !idx_last;
	wire [CW-1:0] ld_idx = go_send ? (fixture ? sel_q : '0) : idx_q + CW'(1);
	wire ld = go_send || next_rec;

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			menu_q <= GPTE_MN_RUN;
			sel_q <= '0;
		end else begin
			unique case (menu_q)
				GPTE_MN_RUN: begin
					if (press) begin
						menu_q <= GPTE_MN_PROMPT;
					end else if (rotate_step_i && ncm1 != '0) begin
						sel_q <= (sel_q >= ncm1) ? '0 : sel_q + CW'(1);
					end
				end
				GPTE_MN_PROMPT: begin
					if (press) menu_q <= GPTE_MN_SEND;
				end
				GPTE_MN_SEND: begin
					if (rec_take && idx_last) menu_q <= GPTE_MN_RUN;
				end
				default: menu_q <= GPTE_MN_RUN;
			endcase
		end
	end

	// Record fields are frozen while a record waits for the receiver
	wire signed [W-1:0] r_max = max_w[ld_idx];
	wire signed [W-1:0] r_min = min_w[ld_idx];
	wire r_out = outside(r_max, r_min, hi, lo);
	wire signed [W-1:0] r_val = eval_of(fn, live_w[ld_idx], r_max, r_min, r_out);
	gpte_stat_t r_st;
	assign r_st = stat_of(r_val, r_min, (fn == GPTE_FN_LIMIT) && r_out, hi, lo);
	logic [W-1:0] rec_val_q;
	logic [1:0] rec_st_q;
	logic [1:0] rec_scale_q;
	logic rec_cls_q;

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			idx_q <= '0;
			rec_valid_q <= 1'b0;
			rec_val_q <= '0;
			rec_st_q <= GPTE_ST_IN;
			rec_scale_q <= GPTE_SCALE_RST;
			rec_cls_q <= 1'b0;
		end else begin
			if (ld) begin
				idx_q <= ld_idx;
				rec_val_q <= r_val;
				rec_st_q <= r_st;
				rec_scale_q <= scale_q;
				rec_cls_q <= (fn == GPTE_FN_LIMIT);
			end
			rec_valid_q <= ld || (rec_valid_q && !rec_ready_i);
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			hrdata_q <= 32'h0;
		end else if (acc_rd) begin
			unique case (ra)
				GPTE_OFF_CTRL: hrdata_q <= ctrl_q;
				GPTE_OFF_ARST: hrdata_q <= arst_q;
				GPTE_OFF_LIMIT: hrdata_q <= limit_q;
				GPTE_OFF_SCALE: hrdata_q <= {30'h0, scale_q};
				GPTE_OFF_VIEW: hrdata_q <= {10'h0, menu_q, disp_st_q, sel_q, disp_value_q};
				default: hrdata_q <= 32'h0;
			endcase
		end
	end

	assign hrdata_o = hrdata_q;
	assign hreadyout_o = 1'b1;
	assign hresp_o = 1'b0;
	assign disp_value_o = disp_value_q;
	assign disp_aux_o = disp_aux_q;
	assign disp_dual_o = disp_dual_q;
	assign disp_check_o = sel_q;
	assign disp_status_o = disp_st_q;
	assign offload_prompt_o = (menu_q == GPTE_MN_PROMPT);
	assign rec_valid_o = rec_valid_q;
	assign rec_check_o = idx_q;
	assign rec_result_o = rec_val_q;
	assign rec_scale_o = rec_scale_q;
	assign rec_status_o = rec_st_q;
	assign rec_class_o = rec_cls_q ? rec_st_q : 2'h0;
	assign rec_class_vld_o = rec_cls_q;
	assign rec_last_o = idx_last;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);

	property p_clr_load;
		hold_clr |=> (max_w[0] == $past(live_w[0])) && (min_w[0] == $past(live_w[0]));
	endproperty
	a_clr_load: assert property (p_clr_load) else $error("peaks not reloaded");
	property p_max_rise;
		!hold_clr |=> max_w[1] >= $past(max_w[1]);
	endproperty
	a_max_rise: assert property (p_max_rise) else $error("max fell");
	property p_min_fall;
		!hold_clr |=> min_w[1] <= $past(min_w[1]);
	endproperty
	a_min_fall: assert property (p_min_fall) else $error("min rose");
	property p_runout;
		fn == GPTE_FN_RUNOUT |=> disp_value_o == W'($past(s_max) - $past(s_min));
	endproperty
	a_runout: assert property (p_runout) else $error("runout wrong");
	property p_auto;
		auto_en && !hold_clr |=> arst_cnt_q == $past(arst_cnt_q) + 32'h1;
	endproperty
	a_auto: assert property (p_auto) else $error("auto count stuck");
	property p_bypass;
		fn == GPTE_FN_BYPASS |=> disp_value_o == $past(s_live) && !disp_dual_o;
	endproperty
	a_bypass: assert property (p_bypass) else $error("bypass wrong");
	property p_step;
		menu_q == GPTE_MN_RUN && !press && rotate_step_i && ncm1 != '0 |=> sel_q != $past(sel_q);
	endproperty
	a_step: assert property (p_step) else $error("no step");
	property p_lim_in;
		fn == GPTE_FN_LIMIT && !s_out |=> !disp_dual_o && disp_value_o == $past(avg_of(s_max, s_min));
	endproperty
	a_lim_in: assert property (p_lim_in) else $error("avg not shown");
	property p_lim_out;
		fn == GPTE_FN_LIMIT && s_out |=> disp_dual_o && disp_aux_o == $past(s_min);
	endproperty
	a_lim_out: assert property (p_lim_out) else $error("peaks not shown");
	property p_two_press;
		menu_q == GPTE_MN_RUN && press ##1 press |=> rec_valid_o;
	endproperty
	a_two_press: assert property (p_two_press) else $error("send not started");
	property p_fix_one;
		rec_valid_o && fixture |-> rec_last_o && rec_check_o == sel_q;
	endproperty
	a_fix_one: assert property (p_fix_one) else $error("fixture sent more");
	property p_hold_rec;
		rec_valid_o && !rec_ready_i |=> rec_valid_o && $stable(rec_result_o);
	endproperty
	a_hold_rec: assert property (p_hold_rec) else $error("record changed");
	property p_single_fn;
		pg == GPTE_PG_SINGLE |-> fn != GPTE_FN_AVG && fn != GPTE_FN_LIMIT;
	endproperty
	a_single_fn: assert property (p_single_fn) else $error("bad single fn");

	c_send_all: cover property (rec_take && idx_last && !fixture && ncm1 == 2'h3);
	c_lim_out: cover property (fn == GPTE_FN_LIMIT && disp_dual_o);
	c_pedal: cover property (menu_q == GPTE_MN_PROMPT && foot_pedal_i);
endmodule : gpte_eval
`default_nettype wire

// ---- gpte_eval_bench.sv ----
// Self-checking bench for the gauge peak and runout evaluator.
// Assumes a zero-wait bus slave and a record receiver model beside it.
`timescale 1ns/1ns
`default_nettype none
module gpte_eval_bench;
	import gpte_pkg::*;
	// ----------------------------------------
	// Stimulus and wires
	// ----------------------------------------
	logic clock_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h0;
	logic [31:0] hwdata = 32'h0;
	logic [3:0] ops = 4'h0;
	logic stall = 1'b0;
	logic [W-1:0] live [NCHK] = '{16'h0, 16'h0, 16'h0, 16'h0};
	int fail_count = 0;
	int total_checks = 0;
	wire logic [31:0] hrdata;
	wire logic hready;
	wire logic hresp;
	wire logic [1:0] rstat;
	wire logic [W-1:0] dval;
	wire logic [W-1:0] daux;
	wire logic ddual;
	wire logic [CW-1:0] dchk;
	wire logic [1:0] dstat;
	wire logic prompt;
	wire logic rvalid;
	wire logic rready;
	wire logic [CW-1:0] rchk;
	wire logic [W-1:0] rres;
	wire logic [1:0] rscale;
	wire logic [1:0] rclass;
	wire logic rcv;
	wire logic rlast;
	wire logic [NCHK*W-1:0] reading = {live[3], live[2], live[1], live[0]};
	wire logic [25:0] rec_word = {rstat, rlast, rcv, rclass, rscale, rchk, rres};

	gpte_eval dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .hsel_i(hsel), .haddr_i(haddr),
		.htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
		.hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
		.reading_i(reading), .hold_reset_i(ops[0]), .rotate_step_i(ops[1]),
		.select_press_i(ops[2]), .foot_pedal_i(ops[3]), .disp_value_o(dval),
		.disp_aux_o(daux), .disp_dual_o(ddual), .disp_check_o(dchk), .disp_status_o(dstat),
		.offload_prompt_o(prompt), .rec_valid_o(rvalid), .rec_ready_i(rready),
		.rec_check_o(rchk), .rec_result_o(rres), .rec_scale_o(rscale), .rec_status_o(rstat),
		.rec_class_o(rclass), .rec_class_vld_o(rcv), .rec_last_o(rlast));

	gpte_rec_sink sink (.clock_i(clock_i), .rst_n_i(rst_n_i), .stall_i(stall),
		.rec_valid_i(rvalid), .rec_ready_o(rready), .rec_word_i(rec_word));

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic close_out();
		if (fail_count == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : close_out

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		@(posedge clock_i);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= GPTE_HTRANS_NONSEQ;
		hwrite <= wr;
		hsize <= GPTE_HSIZE_WORD;
		do @(posedge clock_i); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clock_i); while (hready !== 1'b1);
		rd = hrdata;
	endtask : ahb

	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		ahb(1'b1, a, d, x);
	endtask : wreg

	task automatic rreg(input string what, input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] x;
		ahb(1'b0, a, 32'h0, x);
		chk(what, exp, x);
		chk("response", 32'h0, {31'h0, hresp});
	endtask : rreg

	// Status against the window of the limit test, hi 100 and lo -100
	function automatic logic [1:0] lim_st(input logic [W-1:0] v);
		return ($signed(v) > 16'sd100) ? 2'h1 : (($signed(v) < -16'sd100) ? 2'h2 : 2'h0);
	endfunction : lim_st

	function automatic logic [31:0] mkctrl(input logic [2:0] fn, input logic [1:0] pg,
		input logic au);
		return {20'h0, 2'h3, 1'b0, au, 2'h0, pg, 1'b0, fn};
	endfunction : mkctrl

	// Bit 0 hold reset, 1 rotate, 2 press, 3 pedal
	task automatic pulse(input logic [3:0] m);
		@(posedge clock_i);
		ops <= m;
		@(posedge clock_i);
		ops <= 4'h0;
	endtask : pulse

	task automatic settle();
		repeat (4) @(posedge clock_i);
		#1;
	endtask : settle

	task automatic lv(input int g, input logic [W-1:0] v);
		@(posedge clock_i);
		live[g] <= v;
		settle();
	endtask : lv

	task automatic vshow(input logic [W-1:0] v);
		chk("display", {16'h0, v}, {16'h0, dval});
	endtask : vshow

	task automatic offload(input logic [3:0] m, input int n, input int first,
		input logic [2:0] cls);
		int base;
		int g;
		base = sink.count_q;
		pulse(m);
		#1;
		chk("prompt", 32'h1, {31'h0, prompt});
		pulse(m);
		for (int k = 0; k < 400 && sink.count_q < base + n; k++) @(posedge clock_i);
		repeat (8) @(posedge clock_i);
		chk("records", base + n, sink.count_q);
		for (int k = 0; k < n; k++) begin
			g = first + k;
			chk("record", {6'h0, lim_st(live[g]), (k == n - 1), cls, 2'h2, 2'(g), live[g]},
				{6'h0, sink.got_q[base + k]});
		end
	endtask : offload

	// ----------------------------------------
	// Clock, watchdog and tests
	// ----------------------------------------
	initial begin
		forever #2 clock_i = ~clock_i;
	end

	initial begin
		#200000;
		fail_count++;
		close_out();
	end

	initial begin
		repeat (20) @(posedge clock_i);
		rst_n_i <= 1'b1;
		rreg("ctrl", GPTE_OFF_CTRL, 32'h0000_0c00);
		rreg("arst", GPTE_OFF_ARST, 32'h0001_0000);
		rreg("limit", GPTE_OFF_LIMIT, 32'h0100_ff00);
		rreg("scale", GPTE_OFF_SCALE, 32'h0);
		rreg("unmapped", 8'h18, 32'h0);
		wreg(GPTE_OFF_SCALE, 32'h2);
		// Single program refuses average and limit window; codes above five fall back
		for (int p = 0; p < 2; p++) begin
			for (int f = 0; f < 8; f++) begin
				wreg(GPTE_OFF_CTRL, mkctrl(3'(f), 2'(p), 1'b0));
				rreg("function", GPTE_OFF_CTRL, mkctrl(
					(f > 5 || (p == 0 && (f == 1 || f == 4))) ? 3'h0 : 3'(f),
					2'(p), 1'b0));
			end
		end
		// Peaks and runout on check 0
		wreg(GPTE_OFF_CTRL, mkctrl(3'h2, 2'h1, 1'b0));
		lv(0, 16'd10);
		pulse(4'h1);
		settle();
		vshow(16'd10);
		lv(0, 16'd50);
		lv(0, 16'hffec);
		lv(0, 16'd30);
		vshow(16'd50);
		wreg(GPTE_OFF_CTRL, mkctrl(3'h3, 2'h1, 1'b0));
		settle();
		vshow(16'hffec);
		wreg(GPTE_OFF_CTRL, mkctrl(3'h5, 2'h1, 1'b0));
		settle();
		vshow(16'd70);
		wreg(GPTE_OFF_CMD, 32'h1);
		settle();
		vshow(16'd0);
		// Automatic reset drops a stale peak without a press
		wreg(GPTE_OFF_ARST, 32'h8);
		wreg(GPTE_OFF_CTRL, mkctrl(3'h2, 2'h1, 1'b1));
		lv(0, 16'd500);
		lv(0, 16'd5);
		repeat (12) @(posedge clock_i);
		vshow(16'd5);
		// Bypass and selector steps, wrapping back to check 0
		wreg(GPTE_OFF_CTRL, mkctrl(3'h0, 2'h1, 1'b0));
		lv(1, 16'd111);
		lv(2, 16'd222);
		lv(3, 16'd333);
		for (int g = 1; g <= NCHK; g++) begin
			pulse(4'h2);
			settle();
			chk("check", g % NCHK, {30'h0, dchk});
			vshow(live[g % NCHK]);
		end
		lv(0, 16'd77);
		vshow(16'd77);
		// Limit window: inside shows average, outside shows both peaks
		wreg(GPTE_OFF_LIMIT, 32'h0064_ff9c);
		wreg(GPTE_OFF_CTRL, mkctrl(3'h4, 2'h1, 1'b0));
		lv(0, 16'd20);
		pulse(4'h1);
		lv(0, 16'd40);
		vshow(16'd30);
		chk("dual", 32'h0, {31'h0, ddual});
		lv(0, 16'd150);
		vshow(16'd150);
		chk("aux", 32'd20, {16'h0, daux});
		chk("dual", 32'h1, {31'h0, ddual});
		chk("status", 32'h1, {30'h0, dstat});
		lv(0, 16'hff88);
		pulse(4'h1);
		settle();
		chk("status", 32'h2, {30'h0, dstat});
		// Offload: every check by pedal to a slow receiver, then one fixture
		wreg(GPTE_OFF_CTRL, mkctrl(3'h0, 2'h0, 1'b0));
		stall <= 1'b1;
		offload(4'h8, NCHK, 0, 3'h0);
		stall <= 1'b0;
		// Fixture under the limit window: peaks of check 2 sit at 222, class applies
		wreg(GPTE_OFF_CTRL, mkctrl(3'h4, 2'h2, 1'b0));
		pulse(4'h2);
		pulse(4'h2);
		settle();
		offload(4'h4, 1, 2, 3'h5);
		close_out();
	end
endmodule : gpte_eval_bench
`default_nettype wire

// ---- gpte_peak_track.sv ----
// Running maximum and minimum of one live check reading.
// Assumes the clear strobe is a one-cycle pulse in the same clock domain.
`timescale 1ns/1ns
`default_nettype none
module gpte_peak_track
	import gpte_pkg::*;
(
	// Clock and reset
	input wire logic clock_i,
	input wire logic rst_n_i,
	// Reading and control
	input wire logic signed [W-1:0] live_i,
	input wire logic clear_i,
	// Peaks
	output logic signed [W-1:0] max_o,
	output logic signed [W-1:0] min_o
);
	logic signed [W-1:0] max_q;
	logic signed [W-1:0] min_q;
	logic signed [W-1:0] max_d;
	logic signed [W-1:0] min_d;

	// Clear restarts both peaks at the present reading
	assign max_d = clear_i ? live_i : ((live_i > max_q) ? live_i : max_q);
	assign min_d = clear_i ? live_i : ((live_i < min_q) ? live_i : min_q);

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			max_q <= '0;
			min_q <= '0;
		end else begin
			max_q <= max_d;
			min_q <= min_d;
		end
	end

	assign max_o = max_q;
	assign min_o = min_q;
endmodule : gpte_peak_track
`default_nettype wire

// ---- gpte_pkg.sv ----
// Constants and types for the gauge peak and runout evaluator.
// Assumes one 250 MHz system clock and AHB-Lite register access.
package gpte_pkg;

	// ----------------------------------------
	// Sizes
	// ----------------------------------------
	localparam int NCHK = 4;
	localparam int W = 16;
	localparam int CW = 2;

	// ----------------------------------------
	// Modes and states
	// ----------------------------------------
	typedef enum logic [2:0] {
		GPTE_FN_BYPASS = 3'h0,
		GPTE_FN_AVG = 3'h1,
		GPTE_FN_MAX = 3'h2,
		GPTE_FN_MIN = 3'h3,
		GPTE_FN_LIMIT = 3'h4,
		GPTE_FN_RUNOUT = 3'h5
	} gpte_func_t;

	typedef enum logic [1:0] {
		GPTE_PG_SINGLE = 2'h0,
		GPTE_PG_MULTI = 2'h1,
		GPTE_PG_FIXTURE = 2'h2
	} gpte_prog_t;

	typedef enum logic [1:0] {
		GPTE_ST_IN = 2'h0,
		GPTE_ST_OVER = 2'h1,
		GPTE_ST_UNDER = 2'h2
	} gpte_stat_t;

	typedef enum logic [1:0] {
		GPTE_MN_RUN = 2'h0,
		GPTE_MN_PROMPT = 2'h1,
		GPTE_MN_SEND = 2'h2
	} gpte_menu_t;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [7:0] GPTE_OFF_CTRL = 8'h00;
	localparam logic [7:0] GPTE_OFF_ARST = 8'h04;
	localparam logic [7:0] GPTE_OFF_LIMIT = 8'h08;
	localparam logic [7:0] GPTE_OFF_SCALE = 8'h0c;
	localparam logic [7:0] GPTE_OFF_VIEW = 8'h10;
	localparam logic [7:0] GPTE_OFF_CMD = 8'h14;

	localparam int GPTE_CTRL_FN_LSB = 0;
	localparam int GPTE_CTRL_PG_LSB = 4;
	localparam int GPTE_CTRL_AUTO_BIT = 8;
	localparam int GPTE_CTRL_NCHK_LSB = 10;
	localparam int GPTE_LIMIT_HI_LSB = 16;
	localparam int GPTE_VIEW_CHK_LSB = 16;
	localparam int GPTE_VIEW_ST_LSB = 18;
	localparam int GPTE_VIEW_MN_LSB = 20;
	localparam int GPTE_CMD_CLR_BIT = 0;

	localparam logic [31:0] GPTE_CTRL_RST = 32'h0000_0c00;
	localparam logic [31:0] GPTE_ARST_RST = 32'h0001_0000;
	localparam logic [31:0] GPTE_LIMIT_RST = 32'h0100_ff00;
	localparam logic [1:0] GPTE_SCALE_RST = 2'h0;

	localparam logic [1:0] GPTE_HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] GPTE_HSIZE_WORD = 3'h2;

endpackage : gpte_pkg

// ---- gpte_rec_sink.sv ----
// Record receiver standing in for the printer, data collector or PC.
// Assumes records arrive on a valid/ready handshake in the clock_i domain.
`timescale 1ns/1ns
`default_nettype none
module gpte_rec_sink (
	// Clock and reset
	input wire logic clock_i,
	input wire logic rst_n_i,
	// Pacing
	input wire logic stall_i,
	// Record stream
	input wire logic rec_valid_i,
	output logic rec_ready_o,
	input wire logic [25:0] rec_word_i
);
	// ----------------------------------------
	// Capture
	// ----------------------------------------
	logic [25:0] got_q [0:63];
	int count_q;
	logic phase_q;

	// A slow receiver takes every other cycle, so fields must hold while stalled
	assign rec_ready_o = !stall_i || phase_q;

	always @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			count_q <= 0;
			phase_q <= 1'b0;
		end else begin
			phase_q <= !phase_q;
			if (rec_valid_i && rec_ready_o) begin
				got_q[count_q] <= rec_word_i;
				count_q <= count_q + 1;
			end
		end
	end
endmodule : gpte_rec_sink
`default_nettype wire
